//--- tmr_defines.svh
// Constants for the auto-reload timer with PWM and pulse generator
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define CNT_RESET_VAL 8'h00
`define CNT_FULL_SCALE 8'hff
`define RELOAD_RESET_VAL 8'h00
`define DUTY_RESET_VAL 8'h00
`define PRESCALE_W 8
`define CKS_INSTR 1'b0
`define CKS_HOSC 1'b1
`define TRIG_BIT 1'b0
`define TRIG_CMP 1'b1
`define OVF_VECTOR 16'h000c
`endif

//--- tmr_pkg.sv
// Types shared by the timer design files
package tmr_pkg;
    typedef logic [7:0] byte_t;
    typedef struct packed {
        logic timer_run_enable;
        logic [2:0] prescale_select;
        logic clock_source_select;
        logic output_phase_select;
        logic pulse_mode_enable;
        logic pulse_trigger_select;
    } mode_cfg_s;
    typedef enum logic [2:0] {
        PG_IDLE = 3'b001,
        PG_WAIT = 3'b010,
        PG_RUN = 3'b100
    } pulse_state_e;
endpackage

//--- tmr_prescaler.sv
// Source select and 8-bit prescaler producing the timer tick
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defines.svh"
module tmr_prescaler #(
    parameter int DIV_W = `PRESCALE_W
) (
    input wire logic core_clk_in, // System clock
    input wire logic nrst_in, // Synchronous reset, active low
    input wire logic run_in, // Prescaler runs while high
    input wire logic instr_tick_in, // Instruction clock enable pulse
    input wire logic hosc_tick_in, // High-speed oscillator enable pulse
    input wire logic clock_source_select_in, // 0 instruction, 1 oscillator
    input wire logic [2:0] prescale_select_in, // 000 = /256 .. 111 = /2
    output logic tick_out // One-cycle timer tick
);
    logic [DIV_W-1:0] div_q;
    logic src_tick;
    logic [DIV_W-1:0] mask;

    // Mask of low divider bits; divisor is 2^(8 - code)
    function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] code);
        div_mask = DIV_W'({DIV_W{1'b1}} >> code);
    endfunction

    // Source mux
    assign src_tick = (clock_source_select_in == `CKS_HOSC) ? hosc_tick_in
                                                             : instr_tick_in; // see RULE9
    assign mask = div_mask(prescale_select_in); // see RULE10

    // Divider held cleared while stopped so a restart gives a full period
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || !run_in) begin
            div_q <= '0; // see RULE20
        end else if (src_tick) begin
            div_q <= DIV_W'(div_q + 1'b1);
        end
    end

    assign tick_out = run_in && src_tick && ((div_q & mask) == mask); // see RULE10
endmodule
`default_nettype wire

//--- tmr_edge_detect.sv
// Edge detector for the comparator trigger input
`timescale 1ns/10ps
`default_nettype none
module tmr_edge_detect (
    input wire logic core_clk_in, // System clock
    input wire logic nrst_in, // Synchronous reset, active low
    input wire logic level_in, // Comparator output level
    input wire logic falling_sel_in, // 0 rising, 1 falling
    output logic edge_out // One-cycle pulse on selected edge
);
    logic prev_q;

    // Previous sample of the level
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            // Start from the pin's own level so a high idle gives no false edge after reset
            prev_q <= level_in;
        end else begin
            prev_q <= level_in;
        end
    end

    assign edge_out = falling_sel_in ? (prev_q && !level_in) : (!prev_q && level_in);
endmodule
`default_nettype wire

//--- auto_reload_timer_pwm_pulse.sv
// 8-bit auto-reload timer with PWM output and one-shot pulse generator
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1: Counter increments per timer tick while run enable is set, else holds.
// RULE2: Overflow is the counter wrapping from 0xFF to 0x00.
// RULE3: Overflow sets a sticky flag; only software clears it.
// RULE4: Every overflow reloads the counter from the reload value.
// RULE5: Reload writes take effect only at the next overflow.
// RULE6: With interrupt enable set, overflow raises a request to vector 000CH.
// RULE7: Software clears the overflow flag inside its service routine.
// RULE8: Block keeps running in green mode but never requests wake-up.
// RULE9: Clock source select: 0 instruction clock, 1 high-speed oscillator.
// RULE10: Prescaler divides by 256 for code 000 down to 2 for 111.
// RULE11: Count spans 256 steps of one prescaled tick each.
// RULE12: Software configures mode, source and prescaler before enabling.
// RULE13: PWM cycle from tick rate and reload, duty from compare value.
// RULE14: Pulse mode emits a single waveform cycle per start trigger.
// RULE15: Trigger select: 0 wave control bit, 1 comparator edge.
// RULE16: PWM goes active on enable and overflow, idle at duty match.
// RULE17: Phase select 0 high pulse low idle, 1 low pulse high idle.
// RULE18: Bit trigger: set bit starts; overflow stops, clears bit, flags, reloads.
// RULE19: Comparator trigger: edge starts; overflow stops, flags, reloads.
// RULE20: Prescaler divider resets whenever run enable is cleared.
module auto_reload_timer_pwm_pulse (
    input wire logic core_clk_in, // System clock, 100 MHz
    input wire logic nrst_in, // Synchronous reset, active low
    input wire tmr_pkg::mode_cfg_s cfg_in, // Mode control bits
    input wire logic instr_tick_in, // Instruction clock enable pulse
    input wire logic hosc_tick_in, // Oscillator clock enable pulse
    input wire logic count_wr_in, // Write strobe for count value
    input wire tmr_pkg::byte_t count_wdata_in, // Count value write data
    input wire logic reload_wr_in, // Write strobe for reload value
    input wire tmr_pkg::byte_t reload_wdata_in, // Reload value write data
    input wire logic duty_wr_in, // Write strobe for duty compare
    input wire tmr_pkg::byte_t duty_wdata_in, // Duty compare write data
    input wire logic wave_wr_in, // Write strobe for wave output control
    input wire logic wave_wdata_in, // Wave output control write data
    input wire logic flag_clr_in, // Software clear of overflow flag
    input wire logic overflow_irq_enable_in, // Interrupt enable
    input wire logic green_mode_in, // System in green mode
    input wire logic cmp0_level_in, // Comparator 0 output level
    input wire logic comparator_edge_select_in, // 0 rising, 1 falling
    output tmr_pkg::byte_t count_value_out, // Current count
    output tmr_pkg::byte_t reload_value_out, // Reload buffer
    output tmr_pkg::byte_t duty_compare_value_out, // Duty compare register
    output logic wave_output_control_out, // Wave output control bit
    output logic overflow_flag_out, // Sticky overflow flag
    output logic irq_out, // Interrupt request level
    output logic [15:0] irq_vector_out, // Vector address for request
    output logic wakeup_out, // Wake-up request, never from here
    output logic wave_oe_out, // Pin driven by wave when low
    output logic wave_out // PWM or pulse level
);
    import tmr_pkg::*;

    byte_t count_q, reload_q, duty_q;
    logic wave_ctl_q, flag_q, active_q;
    pulse_state_e pg_q;
    logic tick, cmp_edge, counting, overflow, trigger, wave_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Clock selection and prescaling
    tmr_prescaler #(.DIV_W(`PRESCALE_W)) u_presc (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .run_in(cfg_in.timer_run_enable), // see RULE20
        .instr_tick_in(instr_tick_in),
        .hosc_tick_in(hosc_tick_in),
        .clock_source_select_in(cfg_in.clock_source_select),
        .prescale_select_in(cfg_in.prescale_select),
        .tick_out(tick)
    );

    tmr_edge_detect u_edge (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .level_in(cmp0_level_in),
        .falling_sel_in(comparator_edge_select_in),
        .edge_out(cmp_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pulse generator sequencing; triggers are taken only in the wait state
    assign wave_rise = wave_wr_in && wave_wdata_in && !wave_ctl_q;
    assign trigger = (cfg_in.pulse_trigger_select == `TRIG_CMP) ? cmp_edge
                                                                : wave_rise; // see RULE15

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            pg_q <= PG_IDLE;
        end else begin
            case (pg_q)
                PG_IDLE: begin
                    if (cfg_in.pulse_mode_enable && cfg_in.timer_run_enable) begin
                        pg_q <= PG_WAIT;
                    end
                end
                PG_WAIT: begin
                    if (!cfg_in.pulse_mode_enable || !cfg_in.timer_run_enable) begin
                        pg_q <= PG_IDLE;
                    end else if (trigger) begin
                        pg_q <= PG_RUN; // see RULE14
                    end
                end
                PG_RUN: begin
                    if (!cfg_in.pulse_mode_enable || !cfg_in.timer_run_enable) begin
                        pg_q <= PG_IDLE;
                    end else if (overflow) begin
                        pg_q <= PG_WAIT; // see RULE18, RULE19
                    end
                end
                default: begin
                    pg_q <= PG_IDLE;
                end
            endcase
        end
    end

    // In pulse mode the counter only moves while a pulse is running
    assign counting = cfg_in.timer_run_enable
                      && (!cfg_in.pulse_mode_enable || pg_q == PG_RUN); // see RULE1
    assign overflow = counting && tick && (count_q == `CNT_FULL_SCALE); // see RULE2

    ////////////////////////////////////////////////////////////////////////////
    // Counter: 256 steps, auto-reload on overflow
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            count_q <= `CNT_RESET_VAL;
        end else if (overflow) begin
            count_q <= reload_q; // see RULE4
        end else if (count_wr_in) begin
            count_q <= count_wdata_in;
        end else if (counting && tick) begin
            count_q <= 8'(count_q + 8'h01); // see RULE1, RULE11
        end
    end

    // Reload buffer only reaches the counter at overflow
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            reload_q <= `RELOAD_RESET_VAL;
        end else if (reload_wr_in) begin
            reload_q <= reload_wdata_in; // see RULE5
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            duty_q <= `DUTY_RESET_VAL;
        end else if (duty_wr_in) begin
            duty_q <= duty_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag: set wins over a clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            flag_q <= 1'b0;
        end else if (overflow) begin
            flag_q <= 1'b1; // see RULE3
        end else if (flag_clr_in) begin
            flag_q <= 1'b0; // see RULE7
        end
    end

    // Wave control bit self-clears at the end of a bit-triggered pulse
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            wave_ctl_q <= 1'b0;
        end else if (overflow && cfg_in.pulse_mode_enable
                     && cfg_in.pulse_trigger_select == `TRIG_BIT) begin
            wave_ctl_q <= 1'b0; // see RULE18
        end else if (wave_wr_in) begin
            wave_ctl_q <= wave_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active phase: PWM enable or overflow starts it, duty match ends it
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            active_q <= 1'b0;
        end else if (cfg_in.pulse_mode_enable) begin
            // Pulse lasts from trigger until overflow
            active_q <= (pg_q == PG_RUN && !overflow) || (pg_q == PG_WAIT && trigger); // see RULE14
        end else if (wave_rise || (wave_ctl_q && overflow)) begin
            active_q <= 1'b1; // see RULE16
        end else if (!wave_ctl_q || count_q == duty_q) begin
            active_q <= 1'b0; // see RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive and phase; outputs from flops except handshake-like enable
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            wave_out <= 1'b0;
        end else begin
            wave_out <= active_q ^ cfg_in.output_phase_select; // see RULE17
        end
    end

    // Pin owned by the wave while control bit or pulse mode is set
    assign wave_oe_out = !(wave_ctl_q || cfg_in.pulse_mode_enable); // see RULE13

    // Interrupt is a level from the sticky flag; green mode does not wake
    assign irq_out = flag_q && overflow_irq_enable_in; // see RULE6
    assign irq_vector_out = `OVF_VECTOR; // see RULE6
    assign wakeup_out = 1'b0 & green_mode_in; // see RULE8

    assign count_value_out = count_q;
    assign reload_value_out = reload_q;
    assign duty_compare_value_out = duty_q;
    assign wave_output_control_out = wave_ctl_q;
    assign overflow_flag_out = flag_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_flag_set;
        @(posedge core_clk_in) disable iff (!nrst_in)
        overflow |=> overflow_flag_out;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // see RULE3

    property p_flag_sticky;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (flag_q && !flag_clr_in) |=> flag_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // see RULE3

    property p_reload;
        @(posedge core_clk_in) disable iff (!nrst_in)
        overflow |=> count_q == $past(reload_q);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload"); // see RULE4

    property p_stop;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (!cfg_in.timer_run_enable && !count_wr_in) |=> $stable(count_q);
    endproperty
    a_stop: assert property (p_stop) else $error("counted while off"); // see RULE1

    property p_inc;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (counting && tick && !overflow && !count_wr_in) |=> count_q == 8'($past(count_q) + 8'h01);
    endproperty
    a_inc: assert property (p_inc) else $error("bad increment"); // see RULE1

    property p_irq;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (overflow && overflow_irq_enable_in) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("no irq"); // see RULE6

    property p_bit_clear;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (overflow && cfg_in.pulse_mode_enable && !cfg_in.pulse_trigger_select)
            |=> !wave_ctl_q;
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit kept"); // see RULE18

    property p_pulse_stop;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (overflow && cfg_in.pulse_mode_enable) |=> pg_q != PG_RUN;
    endproperty
    a_pulse_stop: assert property (p_pulse_stop) else $error("pulse ran on"); // see RULE19

    property p_phase;
        @(posedge core_clk_in) disable iff (!nrst_in)
        1'b1 |=> wave_out == ($past(active_q) ^ $past(cfg_in.output_phase_select));
    endproperty
    a_phase: assert property (p_phase) else $error("bad phase"); // see RULE17

    property p_nowake;
        @(posedge core_clk_in) disable iff (!nrst_in)
        green_mode_in |-> !wakeup_out;
    endproperty
    a_nowake: assert property (p_nowake) else $error("woke system"); // see RULE8

    property p_pwm_on;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (wave_rise && !cfg_in.pulse_mode_enable) |=> active_q;
    endproperty
    a_pwm_on: assert property (p_pwm_on) else $error("not active on enable"); // see RULE16

    property p_pwm_restart;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (overflow && wave_ctl_q && !cfg_in.pulse_mode_enable) |=> active_q;
    endproperty
    a_pwm_restart: assert property (p_pwm_restart) else $error("no restart"); // see RULE16

    property p_duty_end;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (wave_ctl_q && !cfg_in.pulse_mode_enable && !overflow && count_q == duty_q) |=> !active_q;
    endproperty
    a_duty_end: assert property (p_duty_end) else $error("no duty end"); // see RULE16

    property p_pulse_idle;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (cfg_in.pulse_mode_enable && pg_q != PG_RUN && !count_wr_in) |=> $stable(count_q);
    endproperty
    a_pulse_idle: assert property (p_pulse_idle) else $error("counted between pulses"); // see RULE14
endmodule
`default_nettype wire

//--- auto_reload_timer_pwm_pulse_tb.sv
// Self-checking testbench for the auto-reload timer with PWM and pulse output
`timescale 1ns/10ps
`default_nettype none
module auto_reload_timer_pwm_pulse_tb;
    import tmr_pkg::*;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    mode_cfg_s cfg = '0;
    logic instr_tick = 1'b1, hosc_tick = 1'b0, flag_clr = 1'b0, irq_en = 1'b0, green = 1'b0;
    logic count_wr = 1'b0, reload_wr = 1'b0, duty_wr = 1'b0, wave_wr = 1'b0, wave_wdata = 1'b0;
    logic cmp0 = 1'b0, edge_sel = 1'b0;
    byte_t count_wdata = 8'h00, reload_wdata = 8'h00, duty_wdata = 8'h00;
    byte_t count_value, reload_value, duty_value;
    logic wave_ctl, flag, irq, wakeup, wave_oe, wave;
    logic [15:0] irq_vector;
    int error_cnt = 0;
    int n_tests = 0;
    always #5 core_clk_in = ~core_clk_in;
    auto_reload_timer_pwm_pulse u_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .cfg_in(cfg), .instr_tick_in(instr_tick), .hosc_tick_in(hosc_tick),
        .count_wr_in(count_wr), .count_wdata_in(count_wdata), .reload_wr_in(reload_wr),
        .reload_wdata_in(reload_wdata), .duty_wr_in(duty_wr), .duty_wdata_in(duty_wdata),
        .wave_wr_in(wave_wr), .wave_wdata_in(wave_wdata), .flag_clr_in(flag_clr),
        .overflow_irq_enable_in(irq_en), .green_mode_in(green), .cmp0_level_in(cmp0),
        .comparator_edge_select_in(edge_sel), .count_value_out(count_value),
        .reload_value_out(reload_value), .duty_compare_value_out(duty_value),
        .wave_output_control_out(wave_ctl), .overflow_flag_out(flag), .irq_out(irq),
        .irq_vector_out(irq_vector), .wakeup_out(wakeup), .wave_oe_out(wave_oe),
        .wave_out(wave));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and comparisons
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check8(input byte_t got, input byte_t exp);
        check16({8'h00, got}, {8'h00, exp});
    endtask
    task automatic check1(input logic got, input logic exp);
        check16({15'h0000, got}, {15'h0000, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Access tasks: inputs change on the falling edge only
    task automatic step();
        @(negedge core_clk_in);
    endtask
    task automatic wr_count(input byte_t v);
        count_wdata = v;
        count_wr = 1'b1;
        step();
        count_wr = 1'b0;
    endtask
    task automatic wr_reload(input byte_t v);
        reload_wdata = v;
        reload_wr = 1'b1;
        step();
        reload_wr = 1'b0;
    endtask
    task automatic wr_duty(input byte_t v);
        duty_wdata = v;
        duty_wr = 1'b1;
        step();
        duty_wr = 1'b0;
    endtask
    task automatic wr_wave(input logic v);
        wave_wdata = v;
        wave_wr = 1'b1;
        step();
        wave_wr = 1'b0;
    endtask
    task automatic clr_flag();
        flag_clr = 1'b1;
        step();
        flag_clr = 1'b0;
    endtask
    // Bounded waits; running out of the bound ends the run as a failure
    task automatic wait_cnt(input byte_t v, input int bound);
        int n;
        n = 0;
        while (count_value !== v && n < bound) begin
            step();
            n++;
        end
        if (count_value !== v) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, count_value, v);
            close_out();
        end
    endtask
    task automatic wait_flag(input int bound);
        int n;
        n = 0;
        while (flag !== 1'b1 && n < bound) begin
            step();
            n++;
        end
        if (flag !== 1'b1) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, flag, 1'b1);
            close_out();
        end
    endtask
    // Cycles between count changes must equal the divisor of the code
    task automatic meas_period(input logic [2:0] code, input logic cks);
        int d, n, k;
        byte_t last;
        d = 1 << (8 - code);
        cfg = '0;
        cfg.prescale_select = code;
        cfg.clock_source_select = cks;
        instr_tick = ~cks;
        hosc_tick = cks;
        wr_count(8'h00);
        cfg.timer_run_enable = 1'b1;
        for (k = 0; k < 2; k++) begin
            last = count_value;
            n = 0;
            while (count_value === last && n < 600) begin
                step();
                n++;
            end
            if (k == 0) check16(16'(n), 16'(d));
            else check16(16'(n), 16'(d));
            check8(count_value, last + 8'h01);
        end
        cfg.timer_run_enable = 1'b0;
        last = count_value;
        repeat (40) step();
        check8(count_value, last);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int k;
        repeat (5) step();
        nrst_in = 1'b1;
        step();
        check8(count_value, 8'h00);
        check1(flag, 1'b0);
        check1(wave, 1'b0);
        check1(wave_oe, 1'b1);
        green = 1'b1;
        // All eight prescaler codes on the instruction clock and code 6 on the oscillator, with the other source's pulses absent
        for (k = 0; k < 8; k++) meas_period(3'(k), 1'b0);
        meas_period(3'h6, 1'b1);
        cfg.clock_source_select = 1'b0;
        instr_tick = 1'b0;
        hosc_tick = 1'b1;
        wr_count(8'h10);
        cfg.timer_run_enable = 1'b1;
        repeat (40) step();
        check8(count_value, 8'h10);
        // Overflow, reload, double-buffered reload, sticky flag, request
        cfg = '0;
        cfg.prescale_select = 3'h7;
        instr_tick = 1'b1;
        hosc_tick = 1'b0;
        irq_en = 1'b1;
        wr_count(8'hfd);
        wr_reload(8'h40);
        check8(reload_value, 8'h40);
        clr_flag();
        cfg.timer_run_enable = 1'b1;
        wait_flag(20);
        check8(count_value, 8'h40);
        check1(irq, 1'b1);
        check16(irq_vector, 16'h000c);
        wr_reload(8'hc0);
        wait_cnt(8'h60, 200);
        check1(flag, 1'b1);
        wait_cnt(8'hff, 600);
        wait_cnt(8'hc0, 4);
        clr_flag();
        check1(flag, 1'b0);
        check1(irq, 1'b0);
        irq_en = 1'b0;
        wait_flag(200);
        check1(irq, 1'b0);
        check1(wakeup, 1'b0);
        // PWM in both phases, with the timer running in green mode
        for (k = 0; k < 2; k++) begin
            cfg = '0;
            cfg.prescale_select = 3'h7;
            cfg.output_phase_select = k[0];
            wr_count(8'h00);
            wr_reload(8'h00);
            wr_duty(8'h80);
            check8(duty_value, 8'h80);
            wr_wave(1'b1);
            cfg.timer_run_enable = 1'b1;
            step();
            check1(wave_oe, 1'b0);
            wait_cnt(8'h40, 300);
            check1(wave, ~k[0]);
            wait_cnt(8'h90, 300);
            check1(wave, k[0]);
            wait_cnt(8'h10, 600);
            check1(wave, ~k[0]);
            wr_wave(1'b0);
            step();
            check1(wave_oe, 1'b1);
        end
        // One-shot pulses: bit trigger, comparator rising, comparator falling
        for (k = 0; k < 3; k++) begin
            cfg = '0;
            cfg.prescale_select = 3'h7;
            cfg.pulse_mode_enable = 1'b1;
            cfg.pulse_trigger_select = (k != 0);
            edge_sel = (k == 2);
            cmp0 = (k == 1);
            wr_count(8'he0);
            wr_reload(8'he0);
            clr_flag();
            cfg.timer_run_enable = 1'b1;
            repeat (3) step();
            if (k != 0) begin
                cmp0 = ~cmp0;
                repeat (6) step();
            end
            check8(count_value, 8'he0);
            if (k == 0) wr_wave(1'b1);
            else cmp0 = ~cmp0;
            wait_cnt(8'hf0, 100);
            check1(wave, 1'b1);
            wait_flag(100);
            check8(count_value, 8'he0);
            repeat (30) step();
            check8(count_value, 8'he0);
            check1(wave, 1'b0);
            check1(wave_ctl, 1'b0);
            check1(flag, 1'b1);
        end
        check1(wakeup, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
